// [adcc_pkg.sv]
// Constants, register map and types of the converter control block.
// Summary of operation
// - The converter interrupt request is served through vector address 53H.
// - Eight analog channels, each conversion giving a 10-bit result into data bytes.
// - Channel-enable register has bit n enabling analog channel n.
// - Writing the start bit, bit 7 of control, launches a conversion on selected channel.
// - Alignment 0 (reset): high byte holds result 9..2, low byte bits 1..0 hold 1..0.
// - Alignment 1: high byte bits 1..0 hold result 9..8, low byte holds 7..0.
// - Control bits 2..0 select the channel numbered by their binary value.
// - Clock select code divides the system clock by two times code plus two.
// - A conversion takes 23 converter clocks, 46 to 1472 system clocks.
package adcc_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_CHAN_EN = 10'h0ab;
   localparam logic [9:0] IDX_CTRL = 10'h0ac;
   localparam logic [9:0] IDX_RES_HIGH = 10'h0ad;
   localparam logic [9:0] IDX_RES_LOW = 10'h0ae;
   localparam logic [9:0] IDX_CLK_DIV = 10'h0af;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h0b0;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h0b1;

   // ----------------------------------------------------------------
   // Field positions, widths and reset values.
   // ----------------------------------------------------------------
   localparam int CTRL_START_BIT = 7;
   localparam int CTRL_ALIGN_BIT = 6;
   localparam int CHAN_W = 3;
   localparam int CHAN_NUM = 8;
   localparam int DIV_W = 5;
   localparam int RESULT_W = 10;
   localparam int STAT_DONE_BIT = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] IRQ_VECTOR = 8'h53;

   // ----------------------------------------------------------------
   // Timing counts.
   // ----------------------------------------------------------------
   localparam logic [4:0] CONV_TICKS = 5'h17;

   typedef enum logic {ADCC_IDLE, ADCC_CONVERT} adcc_state_t;

endpackage

// [adcc_conv_if.sv]
// Interface joining the control registers, clock divider and sequencer.
`timescale 1ns/100ps
interface adcc_conv_if;
   logic launch;
   logic busy;
   logic done;
   logic tick;
   logic [4:0] div_code;
   logic [9:0] result;

   modport ctrl (output launch, output div_code, input busy, input done, input result,
      input tick);
   modport seq (input launch, input tick, output busy, output done, output result);
   modport div (input busy, input div_code, output tick);
endinterface

// [adcc_clk_div.sv]
// Converter clock divider producing a one-cycle enable pulse.
`timescale 1ns/100ps
module adcc_clk_div (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Divider link.
   adcc_conv_if.div dif
);
   import adcc_pkg::*;

   logic [5:0] count;
   logic [5:0] last;

   // Period is 2 * (code + 1) system clocks; the count restarts while idle.
   assign last = {dif.div_code, 1'b1};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 6'h00;
         dif.tick <= 1'b0;
      end else if (!dif.busy) begin
         count <= 6'h00;
         dif.tick <= 1'b0;
      end else if (count == last) begin
         count <= 6'h00;
         dif.tick <= 1'b1;
      end else begin
         count <= count + 6'h01;
         dif.tick <= 1'b0;
      end
   end
endmodule

// [adcc_seq.sv]
// Conversion sequencer counting converter clocks and capturing the result.
`timescale 1ns/100ps
module adcc_seq (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Analog core result.
   input wire logic [9:0] ana_data,
   // Sequencer link.
   adcc_conv_if.seq sif
);
   import adcc_pkg::*;

   adcc_state_t state;
   logic [4:0] ticks;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ADCC_IDLE;
         ticks <= 5'h00;
         sif.busy <= 1'b0;
         sif.done <= 1'b0;
         sif.result <= 10'h000;
      end else begin
         sif.done <= 1'b0;
         case (state)
            ADCC_IDLE: begin
               if (sif.launch) begin
                  state <= ADCC_CONVERT;
                  ticks <= 5'h00;
                  sif.busy <= 1'b1;
               end
            end
            ADCC_CONVERT: begin
               if (sif.tick) begin
                  if (ticks == CONV_TICKS - 5'h01) begin
                     state <= ADCC_IDLE;
                     sif.busy <= 1'b0;
                     sif.done <= 1'b1;
                     sif.result <= ana_data;
                  end else begin
                     ticks <= ticks + 5'h01;
                  end
               end
            end
            default: begin
               state <= ADCC_IDLE;
               sif.busy <= 1'b0;
            end
         endcase
      end
   end
endmodule

// [adcc_top.sv]
// Top of the converter control block with its APB register file.
`timescale 1ns/100ps
module adcc_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt.
   output logic irq,
   output logic [7:0] irq_vector,
   // Analog core.
   output logic [adcc_pkg::CHAN_NUM-1:0] ana_enable,
   output logic [adcc_pkg::CHAN_W-1:0] ana_channel,
   output logic ana_sample,
   output logic ana_clk_tick,
   input wire logic [adcc_pkg::RESULT_W-1:0] ana_data
);
   import adcc_pkg::*;

   adcc_conv_if cif ();

   logic [7:0] chan_en;
   logic start;
   logic align;
   logic [CHAN_W-1:0] chan_sel;
   logic [DIV_W-1:0] clk_div;
   logic [7:0] res_high;
   logic [7:0] res_low;
   logic irq_status;
   logic irq_mask;
   logic [9:0] idx;
   logic setup;
   logic wr;
   logic mapped;
   logic [7:0] rd_byte;

   // ----------------------------------------------------------------
   // Submodules.
   // ----------------------------------------------------------------
   adcc_clk_div u_div (
      .clk(clk),
      .rst_n(rst_n),
      .dif(cif.div)
   );

   adcc_seq u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .ana_data(ana_data),
      .sif(cif.seq)
   );

   // ----------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------
   assign idx = paddr[ADDR_W-1:2];
   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite;
   assign cif.div_code = clk_div;

   always_comb begin
      mapped = 1'b1;
      rd_byte = RESET_BYTE;
      case (idx)
         IDX_CHAN_EN: rd_byte = chan_en;
         IDX_CTRL: rd_byte = {start, align, 3'h0, chan_sel};
         IDX_RES_HIGH: rd_byte = res_high;
         IDX_RES_LOW: rd_byte = res_low;
         IDX_CLK_DIV: rd_byte = {3'h0, clk_div};
         IDX_IRQ_STATUS: rd_byte = {7'h00, irq_status};
         IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask};
         default: mapped = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer, zero wait states.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_en <= RESET_BYTE;
         align <= 1'b0;
         chan_sel <= 3'h0;
         clk_div <= 5'h00;
         irq_mask <= 1'b0;
      end else if (wr && !pslverr) begin
         if (idx == IDX_CHAN_EN) begin
            chan_en <= pwdata[7:0];
         end
         if (idx == IDX_CTRL) begin
            align <= pwdata[CTRL_ALIGN_BIT];
            chan_sel <= pwdata[CHAN_W-1:0];
         end
         if (idx == IDX_CLK_DIV) begin
            clk_div <= pwdata[DIV_W-1:0];
         end
         if (idx == IDX_IRQ_MASK) begin
            irq_mask <= pwdata[STAT_DONE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Start bit, launch pulse and channel steering.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start <= 1'b0;
         cif.launch <= 1'b0;
         ana_channel <= 3'h0;
      end else begin
         cif.launch <= 1'b0;
         if (cif.done) begin
            start <= 1'b0;
         end else if (wr && idx == IDX_CTRL && pwdata[CTRL_START_BIT] && !start) begin
            start <= 1'b1;
            cif.launch <= 1'b1;
            ana_channel <= pwdata[CHAN_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Result bytes.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_high <= RESET_BYTE;
         res_low <= RESET_BYTE;
      end else if (cif.done) begin
         if (!align) begin
            res_high <= cif.result[9:2];
            res_low <= {6'h00, cif.result[1:0]};
         end else begin
            res_high <= {6'h00, cif.result[9:8]};
            res_low <= cif.result[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, mask and output.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 1'b0;
         irq <= 1'b0;
         irq_vector <= IRQ_VECTOR;
      end else begin
         irq_vector <= IRQ_VECTOR;
         // A completion in the clearing cycle keeps the bit set.
         if (cif.done) begin
            irq_status <= 1'b1;
         end else if (wr && idx == IDX_IRQ_STATUS && pwdata[STAT_DONE_BIT]) begin
            irq_status <= 1'b0;
         end
         irq <= (irq_status | cif.done) & irq_mask & ~(wr && idx == IDX_IRQ_STATUS
            && pwdata[STAT_DONE_BIT] && !cif.done);
      end
   end

   // ----------------------------------------------------------------
   // Analog core drive.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ana_enable <= RESET_BYTE;
         ana_sample <= 1'b0;
         ana_clk_tick <= 1'b0;
      end else begin
         ana_enable <= chan_en;
         ana_sample <= cif.busy;
         ana_clk_tick <= cif.tick;
      end
   end
endmodule

// [adcc_props.sv]
// Port assertions for the converter control top.
`timescale 1ns/100ps
module adcc_props (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Interrupt and analog side.
   input wire logic [7:0] irq_vector,
   input wire logic [7:0] ana_enable,
   input wire logic [2:0] ana_channel,
   input wire logic ana_sample,
   input wire logic ana_clk_tick
);
   logic [4:0] tcnt;
   wire acc = psel && penable && pready && pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tcnt <= 5'h00;
      else if (!ana_sample) tcnt <= 5'h00;
      else if (ana_clk_tick) tcnt <= tcnt + 5'h01;
   end
   property p_vec; irq_vector == 8'h53; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_en;
      acc && paddr == 12'h2ac |=> ##1 {24'h0, ana_enable} == ($past(pwdata, 2) & 32'hff);
   endproperty
   a_en: assert property (p_en) else $error("enable lost");
   property p_go; acc && paddr == 12'h2b0 && pwdata[7] && !ana_sample |-> ##[1:4] ana_sample;
   endproperty
   a_go: assert property (p_go) else $error("no launch");
   property p_ch; ana_sample && $past(ana_sample) |-> $stable(ana_channel); endproperty
   a_ch: assert property (p_ch) else $error("channel moved");
   property p_gap; ana_clk_tick |=> !ana_clk_tick; endproperty
   a_gap: assert property (p_gap) else $error("tick too fast");
   property p_min; $rose(ana_sample) |-> ana_sample[*8]; endproperty
   a_min: assert property (p_min) else $error("short run");
   property p_cnt; $fell(ana_sample) |-> tcnt == 5'h17; endproperty
   a_cnt: assert property (p_cnt) else $error("tick count");
   property p_in; ana_clk_tick |-> ana_sample; endproperty
   a_in: assert property (p_in) else $error("stray tick");
endmodule
bind adcc_top adcc_props u_adcc_props (
   .clk(clk),
   .rst_n(rst_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .irq_vector(irq_vector),
   .ana_enable(ana_enable),
   .ana_channel(ana_channel),
   .ana_sample(ana_sample),
   .ana_clk_tick(ana_clk_tick)
);

// [adcc_ana_model.sv]
// Behavioural analog multiplexer and converter core.
`timescale 1ns/100ps
module adcc_ana_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control side.
   input wire logic [7:0] ana_enable,
   input wire logic [2:0] ana_channel,
   input wire logic ana_sample,
   // Test level and result.
   input wire logic [6:0] level,
   output logic [9:0] ana_data
);
   logic [9:0] last;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) last <= 10'h000;
      else if (ana_sample) last <= ana_data;
   end
   // Outside a conversion the output is invalid and shows the inverse of the last value.
   always_comb begin
      if (!ana_sample) ana_data = ~last;
      else if (ana_enable[ana_channel]) ana_data = {ana_channel, level};
      else ana_data = ~{ana_channel, level};
   end
endmodule

// [adcc_tb_top.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module adcc_tb_top;
   import adcc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [6:0] level = 7'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, ana_sample, ana_clk_tick, err, mask;
   logic [7:0] irq_vector, ana_enable;
   logic [2:0] ana_channel;
   logic [9:0] ana_data;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   adcc_top u_adcc_top (
      .clk(clk),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq),
      .irq_vector(irq_vector),
      .ana_enable(ana_enable),
      .ana_channel(ana_channel),
      .ana_sample(ana_sample),
      .ana_clk_tick(ana_clk_tick),
      .ana_data(ana_data)
   );
   adcc_ana_model u_adcc_ana_model (
      .clk(clk),
      .rst_n(rst_n),
      .ana_enable(ana_enable),
      .ana_channel(ana_channel),
      .ana_sample(ana_sample),
      .level(level),
      .ana_data(ana_data)
   );
   // Raw result that the analog side hands over for a channel and test level.
   function automatic logic [9:0] exp_raw(input logic [2:0] ch, input logic [6:0] lv,
      input logic on);
      return on ? {ch, lv} : ~{ch, lv};
   endfunction
   // Result bytes, high then low, for the given alignment.
   function automatic logic [15:0] exp_bytes(input logic [9:0] r, input logic al);
      return al ? {6'h00, r} : {r[9:2], 6'h00, r[1:0]};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task conv(input logic [2:0] ch, input logic al, input logic [4:0] code);
      int t0;
      logic [7:0] en;
      logic [9:0] r;
      logic [15:0] f;
      en = 8'($urandom);
      level <= 7'($urandom);
      apb(1'b1, IDX_CHAN_EN, {24'h0, en});
      apb(1'b1, IDX_CLK_DIV, {27'h0, code});
      apb(1'b1, IDX_CTRL, {24'h0, 1'b1, al, 3'h0, ch});
      t0 = cyc;
      rd = 32'h80;
      while (rd[7] === 1'b1 && cyc - t0 < 3000) apb(1'b0, IDX_CTRL, 32'h0);
      chk(rd, {24'h0, 1'b0, al, 3'h0, ch});
      t0 = cyc - t0 - 46 * (code + 1);
      chk(32'(t0 >= 0 && t0 <= 10), 32'h1);
      r = exp_raw(ch, level, en[ch]);
      f = exp_bytes(r, al);
      apb(1'b0, IDX_RES_HIGH, 32'h0);
      chk(rd, {24'h0, f[15:8]});
      apb(1'b0, IDX_RES_LOW, 32'h0);
      chk(rd, {24'h0, f[7:0]});
      chk({31'h0, irq}, {31'h0, mask});
      apb(1'b0, IDX_IRQ_STATUS, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
   endtask
   initial begin
      void'($urandom(32'hc36f86b8));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 'h0ab; i <= 'h0b1; i++) begin
         apb(1'b0, 10'(i), 32'h0);
         chk(rd, 32'h0);
      end
      chk({24'h0, irq_vector}, 32'h53);
      apb(1'b1, 10'h0c0, 32'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, IDX_RES_HIGH, 32'hff);
      apb(1'b0, IDX_RES_HIGH, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, IDX_CHAN_EN, 32'ha5);
      apb(1'b0, IDX_CHAN_EN, 32'h0);
      chk(rd, 32'ha5);
      chk({31'h0, err}, 32'h0);
      mask = 1'b0;
      // Codes from 10 up keep the converter clock and conversion rate within limits.
      conv(3'h5, 1'b0, 5'h0a);
      mask = 1'b1;
      apb(1'b1, IDX_IRQ_MASK, 32'h1);
      for (int i = 0; i < 8; i++) begin
         conv(3'(i), 1'(i),
            (i == 7) ? 5'h1f : (i == 0) ? 5'h0a : 5'($urandom_range(13, 10)));
      end
      final_report;
   end
   initial begin
      #100000;
      error_cnt++;
      final_report;
   end
endmodule
